// >>> waveform_state_instruction_decoder.sv
// Summary of operation
// - Fixed state lasts length cycles, zero means 256
// - Decision state branches on true or false
// - Repeat bit reruns task every loop cycle
// - Operation bit 0 selects decision state
// - Single bit uses single/crc only in FIFO waves
// - Advance bit steps OUT FIFO at entry
// - With single bit, bit 2 picks crc
// - Interrupt bit pulses state interrupt on entry
// - Address bit increments address bus on entry
// - Write waves drive data bus when data set
// - Read waves sample data bus when data set
// - Term codes pick handshake, FIFO flag, firmware ready
// - Config bit 5 swaps code 101 to count-expired
// - Function codes: AND, OR, XOR, AND
// - Terms sampled each edge, branch next edge
// - Logic byte ignored in fixed states
// - Output byte sets six control levels
// - Tristate mode: upper nibble enables outputs 3..0
// - Pin config bit makes control output open-drain
// - Control task runs on state entry, rerun each cycle by repeat bit in decision states
// - Decision state lasts at least one cycle
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module waveform_state_instruction_decoder
  import wfe_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Register port
  input  wire wfe_pkg::reg_req_t     req,
  output var  logic [31:0]           rdata,
  // Handshake and flag inputs
  input  wire logic [5:0]            handshake_inputs,
  input  wire logic                  programmable_fifo_flag,
  input  wire logic                  tc_expired,
  // Data path
  input  wire logic [15:0]           out_fifo_word,
  input  wire logic [15:0]           data_bus_in,
  output var  wfe_pkg::data_pins_t   data_bus_out,
  output var  logic                  fifo_advance,
  output var  logic                  fifo_store,
  output var  logic [15:0]           fifo_store_word,
  // Control pins and status
  output var  wfe_pkg::ctl_pins_t    control_pins,
  output var  logic [8:0]            waveform_address_bus,
  output var  logic                  waveform_state_interrupt,
  output var  logic                  waveform_done
);
  import wfe_pkg::*;

  eng_state_t s;
  eng_state_t n;

  always_comb begin : next_logic
    logic [31:0] cur_ins;
    logic [31:0] nxt_ins;
    logic [7:0]  len_b;
    logic [7:0]  op_b;
    logic [7:0]  lf_b;
    logic [7:0]  out_b;
    logic [7:0]  remain;
    logic        sgl_eff;
    logic        nxt_sgl;
    logic        task_now;
    logic        ta;
    logic        tb;
    logic        res;
    logic [2:0]  tgt;
    logic [5:0]  lv;
    logic [5:0]  en;
    cur_ins  = (s.cur == IDLE_STATE) ? INSTR_RST : s.instr[s.cur];
    len_b    = cur_ins[LANE_LEN_BRANCH +: 8];
    op_b     = cur_ins[LANE_OPERATION +: 8];
    lf_b     = cur_ins[LANE_LOGIC +: 8];
    nxt_ins  = INSTR_RST;
    out_b    = 8'h00;
    nxt_sgl  = 1'b0;
    lv       = 6'h00;
    en       = 6'h00;
    sgl_eff  = op_b[OP_SINGLE] & s.fifo_mode;
    task_now = 1'b0;
    ta       = 1'b0;
    tb       = 1'b0;
    res      = 1'b0;
    remain   = 8'h00;
    tgt      = s.cur;
    n        = s;
    n.adv    = 1'b0;
    n.irq    = 1'b0;
    n.store  = 1'b0;
    n.done   = 1'b0;
    n.entry  = 1'b0;
    n.rdata  = 32'h0000_0000;
    // Pins pass two flops; first stage read by second only
    n.rdy_s1 = handshake_inputs;
    n.rdy_s2 = s.rdy_s1;
    n.din_s1 = data_bus_in;
    n.din_s2 = s.din_s1;
    // Term sources sampled on every edge
    n.src = {s.ready_cfg[RC_FW_READY], programmable_fifo_flag,
             s.ready_cfg[RC_TC_SELECT] ? tc_expired : s.rdy_s2[5], s.rdy_s2[4:0]};

    if (req.wr) begin
      if (req.addr < REG_INSTR_END && req.addr[1:0] == 2'h0) begin
        n.instr[req.addr[4:2]] = req.wdata;
      end
      case (req.addr)
        REG_READY_CFG:   n.ready_cfg = req.wdata[7:0];
        REG_PIN_CFG:     n.pin_cfg = req.wdata[5:0];
        REG_CONTROL: begin
          n.tri_mode  = req.wdata[CR_TRI_MODE];
          n.fifo_mode = req.wdata[CR_FIFO_WAVE];
          n.write_dir = req.wdata[CR_WRITE_DIR];
          n.idle_lvl  = req.wdata[CR_IDLE_LSB +: 6];
        end
        REG_SINGLE_DATA: n.single_data = req.wdata[15:0];
        REG_CRC_ACCUM:   n.crc_data = req.wdata[15:0];
        REG_WAVE_ADDR:   n.addr = req.wdata[8:0];
        default:         n.rdata = 32'h0000_0000;
      endcase
    end
    if (req.rd) begin
      if (req.addr < REG_INSTR_END && req.addr[1:0] == 2'h0) begin
        n.rdata = s.instr[req.addr[4:2]];
      end
      case (req.addr)
        REG_READY_CFG:   n.rdata = {24'h000000, s.ready_cfg};
        REG_PIN_CFG:     n.rdata = {26'h0000000, s.pin_cfg};
        REG_CONTROL:     n.rdata = {18'h00000, s.idle_lvl, 4'h0, s.write_dir, s.fifo_mode, s.tri_mode, 1'b0};
        REG_STATUS:      n.rdata = {16'h0000, s.cnt, 1'b0, s.cur, 3'h0, (s.phase == PH_RUN)};
        REG_SINGLE_DATA: n.rdata = {16'h0000, s.single_data};
        REG_CRC_ACCUM:   n.rdata = {16'h0000, s.crc_data};
        REG_WAVE_ADDR:   n.rdata = {23'h000000, s.addr};
        default:         n.rdata = n.rdata;
      endcase
    end

    case (s.phase)
      PH_RUN: begin
        // Entry task; a looping decision state may repeat it
        task_now = s.entry | (op_b[OP_DECISION] & len_b[BR_REPEAT_TASK]);
        if (task_now) begin
          if (op_b[OP_ADDR_INC]) begin
            n.addr = s.addr + 9'h001;
          end
          n.adv = op_b[OP_ADVANCE_CRC] & ~sgl_eff & s.fifo_mode & s.write_dir;
          if (op_b[OP_DATA] && !s.write_dir) begin
            if (sgl_eff && op_b[OP_ADVANCE_CRC]) begin
              n.crc_data = s.din_s2;
            end else if (sgl_eff || !s.fifo_mode) begin
              n.single_data = s.din_s2;
            end else begin
              n.store      = 1'b1;
              n.store_data = s.din_s2;
            end
          end
        end
        n.irq = s.entry & op_b[OP_STATE_IRQ];
        if (op_b[OP_DECISION]) begin
          // Branch decided in the entry cycle too, so one cycle minimum
          ta = s.src[lf_b[LF_TERM_A_LSB +: 3]];
          tb = s.src[lf_b[LF_TERM_B_LSB +: 3]];
          case (lf_b[LF_FUNC_LSB +: 2])
            FN_AND:     res = ta & tb;
            FN_OR:      res = ta | tb;
            FN_XOR:     res = ta ^ tb;
            FN_AND_ALT: res = ta & tb;
            default:    res = ta & tb;
          endcase
          tgt = res ? len_b[BR_TRUE_LSB +: 3] : len_b[BR_FALSE_LSB +: 3];
        end else begin
          // Length byte minus one wraps zero into 256 cycles
          remain = s.entry ? len_b - 8'h01 : s.cnt;
          if (remain == 8'h00) begin
            tgt = s.cur + 3'h1;
          end else begin
            n.cnt = remain - 8'h01;
          end
        end
        n.entry = (tgt != s.cur);
        n.cur   = tgt;
        if (tgt == IDLE_STATE) begin
          n.phase = PH_IDLE;
          n.done  = 1'b1;
          n.entry = 1'b0;
        end
      end
      PH_IDLE: begin
        if (req.wr && req.addr == REG_CONTROL && req.wdata[CR_GO]) begin
          n.phase = PH_RUN;
          n.cur   = FIRST_STATE;
          n.entry = 1'b1;
        end
      end
      default: n.phase = PH_IDLE;
    endcase

    // Pin drive follows the state being entered so outputs line up
    nxt_ins = (n.phase == PH_IDLE || n.cur == IDLE_STATE) ? INSTR_RST : n.instr[n.cur];
    out_b   = nxt_ins[LANE_OUTPUT +: 8];
    nxt_sgl = nxt_ins[LANE_OPERATION + OP_SINGLE] & n.fifo_mode;
    if (n.phase == PH_IDLE) begin
      lv = n.idle_lvl;
      en = 6'h3F;
    end else if (n.tri_mode) begin
      lv = {2'h0, out_b[3:0]};
      en = {2'h0, out_b[7:4]};
    end else begin
      lv = out_b[5:0];
      en = 6'h3F;
    end
    // Open-drain releases the pin for a high level
    n.ctl.level = lv & ~n.pin_cfg;
    n.ctl.oe_n  = ~(en & ~(n.pin_cfg & lv));
    n.dout.oe_n = ~((n.phase == PH_RUN) & n.write_dir & nxt_ins[LANE_OPERATION + OP_DATA]);
    if (nxt_sgl && nxt_ins[LANE_OPERATION + OP_ADVANCE_CRC]) begin
      n.dout.value = n.crc_data;
    end else if (nxt_sgl || !n.fifo_mode) begin
      n.dout.value = n.single_data;
    end else begin
      n.dout.value = out_fifo_word;
    end

    if (reset) begin
      n           = '0;
      n.phase     = PH_IDLE;
      n.cur       = IDLE_STATE;
      n.idle_lvl  = IDLE_LEVELS_RST;
      n.ctl.level = IDLE_LEVELS_RST;
      n.ctl.oe_n  = 6'h00;
      n.dout.oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  assign rdata                    = s.rdata;
  assign data_bus_out             = s.dout;
  assign fifo_advance             = s.adv;
  assign fifo_store               = s.store;
  assign fifo_store_word          = s.store_data;
  assign control_pins             = s.ctl;
  assign waveform_address_bus     = s.addr;
  assign waveform_state_interrupt = s.irq;
  assign waveform_done            = s.done;

  // Checker helpers decode the current instruction independently
  logic [31:0] h_ins;
  logic [7:0]  h_len;
  logic [7:0]  h_op;
  logic [7:0]  h_lf;
  logic [7:0]  h_out;
  logic        h_run;
  logic        h_res;
  assign h_ins = (s.cur == IDLE_STATE) ? INSTR_RST : s.instr[s.cur];
  assign h_len = h_ins[7:0];
  assign h_op  = h_ins[15:8];
  assign h_lf  = h_ins[23:16];
  assign h_out = h_ins[31:24];
  assign h_run = (s.phase == PH_RUN);
  assign h_res = (h_lf[7:6] == 2'h1) ? (s.src[h_lf[5:3]] | s.src[h_lf[2:0]]) :
                 (h_lf[7:6] == 2'h2) ? (s.src[h_lf[5:3]] ^ s.src[h_lf[2:0]]) :
                                       (s.src[h_lf[5:3]] & s.src[h_lf[2:0]]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_len_256;
    logic [2:0] c;
    (h_run && s.entry && !h_op[0] && h_len == 8'h00 && !req.wr, c = s.cur) |->
      ##255 (s.cur == c) ##1 (s.cur != c);
  endproperty
  a_len_256: assert property (p_len_256) else $error("zero length did not last 256 cycles");

  property p_branch;
    (h_run && h_op[0] && !req.wr) |=>
      (s.cur == ($past(h_res) ? $past(h_len[5:3]) : $past(h_len[2:0])));
  endproperty
  a_branch: assert property (p_branch) else $error("decision branch target wrong");

  property p_entry_first;
    (h_run && $past(h_run) && s.cur != $past(s.cur)) |-> s.entry;
  endproperty
  a_entry_first: assert property (p_entry_first) else $error("state entered without entry cycle");

  property p_addr_inc;
    (h_run && s.entry && h_op[3] && !req.wr) |=> (s.addr == $past(s.addr) + 9'h001);
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address not incremented on entry");

  property p_repeat;
    (h_run && !s.entry && h_op[0] && h_op[3] && !h_len[7] && !req.wr) |=> $stable(s.addr);
  endproperty
  a_repeat: assert property (p_repeat) else $error("task repeated without repeat bit");

  property p_irq;
    (h_run && s.entry) |=> (s.irq == $past(h_op[4]));
  endproperty
  a_irq: assert property (p_irq) else $error("state interrupt mismatch");

  property p_adv_out_only;
    s.adv |-> (s.write_dir && s.fifo_mode);
  endproperty
  a_adv_out_only: assert property (p_adv_out_only) else $error("advance outside OUT FIFO wave");

  property p_ctl_levels;
    (h_run && !s.tri_mode && s.pin_cfg == 6'h00) |-> (s.ctl.level == h_out[5:0] && s.ctl.oe_n == 6'h00);
  endproperty
  a_ctl_levels: assert property (p_ctl_levels) else $error("control levels differ from output byte");

  property p_ctl_tri;
    (h_run && s.tri_mode && s.pin_cfg == 6'h00) |-> (s.ctl.oe_n == {2'h3, ~h_out[7:4]});
  endproperty
  a_ctl_tri: assert property (p_ctl_tri) else $error("tristate enables wrong");

  property p_open_drain;
    (h_run && !s.tri_mode && s.pin_cfg[0]) |-> (!s.ctl.level[0] && s.ctl.oe_n[0] == h_out[0]);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin not released for high");

  property p_data_drive;
    (h_run && s.write_dir) |-> (s.dout.oe_n == !h_op[1]);
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("data bus drive wrong");

  property p_tc_swap;
    s.ready_cfg[5] |=> (s.src[5] == $past(tc_expired));
  endproperty
  a_tc_swap: assert property (p_tc_swap) else $error("count-expired not selected");

  c_loop_repeat: cover property (h_run && h_op[0] && h_len[7] && !s.entry);
  c_long_state: cover property (h_run && !h_op[0] && s.cnt == 8'hFE);
  c_done: cover property (s.done);
  c_branch_true: cover property (h_run && h_op[0] && h_res && h_len[5:3] != s.cur);

endmodule : waveform_state_instruction_decoder
`default_nettype wire

// >>> wfe_pkg.sv
package wfe_pkg;

  // Instruction store: one 32-bit word per state, byte lanes below
  localparam int         NUM_STATES      = 7;
  localparam logic [2:0] IDLE_STATE      = 3'h7;
  localparam logic [2:0] FIRST_STATE     = 3'h0;
  localparam int         LANE_LEN_BRANCH = 0;
  localparam int         LANE_OPERATION  = 8;
  localparam int         LANE_LOGIC      = 16;
  localparam int         LANE_OUTPUT     = 24;

  // Register byte addresses
  localparam logic [7:0] REG_INSTR_BASE  = 8'h00;
  localparam logic [7:0] REG_INSTR_END   = 8'h1C;
  localparam logic [7:0] REG_READY_CFG   = 8'h20;
  localparam logic [7:0] REG_PIN_CFG     = 8'h24;
  localparam logic [7:0] REG_CONTROL     = 8'h28;
  localparam logic [7:0] REG_STATUS      = 8'h2C;
  localparam logic [7:0] REG_SINGLE_DATA = 8'h30;
  localparam logic [7:0] REG_CRC_ACCUM   = 8'h34;
  localparam logic [7:0] REG_WAVE_ADDR   = 8'h38;

  // Operation byte fields
  localparam int OP_DECISION    = 0;
  localparam int OP_DATA        = 1;
  localparam int OP_ADVANCE_CRC = 2;
  localparam int OP_ADDR_INC    = 3;
  localparam int OP_STATE_IRQ   = 4;
  localparam int OP_SINGLE      = 5;

  // Branch byte and logic function byte fields
  localparam int BR_REPEAT_TASK = 7;
  localparam int BR_TRUE_LSB    = 3;
  localparam int BR_FALSE_LSB   = 0;
  localparam int LF_FUNC_LSB    = 6;
  localparam int LF_TERM_A_LSB  = 3;
  localparam int LF_TERM_B_LSB  = 0;

  // Configuration fields
  localparam int RC_TC_SELECT   = 5;
  localparam int RC_FW_READY    = 7;
  localparam int CR_GO          = 0;
  localparam int CR_TRI_MODE    = 1;
  localparam int CR_FIFO_WAVE   = 2;
  localparam int CR_WRITE_DIR   = 3;
  localparam int CR_IDLE_LSB    = 8;

  // Term combine codes
  localparam logic [1:0] FN_AND     = 2'h0;
  localparam logic [1:0] FN_OR      = 2'h1;
  localparam logic [1:0] FN_XOR     = 2'h2;
  localparam logic [1:0] FN_AND_ALT = 2'h3;

  // Reset values
  localparam logic [5:0]  IDLE_LEVELS_RST = 6'h3F;
  localparam logic [31:0] INSTR_RST       = 32'h0000_0000;

  typedef enum logic {PH_IDLE, PH_RUN} phase_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [5:0] level;
    logic [5:0] oe_n;
  } ctl_pins_t;

  typedef struct packed {
    logic [15:0] value;
    logic        oe_n;
  } data_pins_t;

  typedef struct packed {
    phase_t                        phase;
    logic [2:0]                    cur;
    logic [7:0]                    cnt;
    logic                          entry;
    logic [NUM_STATES-1:0][31:0]   instr;
    logic [7:0]                    ready_cfg;
    logic [5:0]                    pin_cfg;
    logic                          tri_mode;
    logic                          fifo_mode;
    logic                          write_dir;
    logic [5:0]                    idle_lvl;
    logic [15:0]                   single_data;
    logic [15:0]                   crc_data;
    logic [8:0]                    addr;
    logic [5:0]                    rdy_s1;
    logic [5:0]                    rdy_s2;
    logic [15:0]                   din_s1;
    logic [15:0]                   din_s2;
    logic [7:0]                    src;
    ctl_pins_t                     ctl;
    data_pins_t                    dout;
    logic                          adv;
    logic                          irq;
    logic                          store;
    logic                          done;
    logic [15:0]                   store_data;
    logic [31:0]                   rdata;
  } eng_state_t;

endpackage : wfe_pkg

// >>> peripheral_model.sv
`timescale 1ns/1ns
`default_nettype none
module peripheral_model #(
  parameter logic [15:0] READ_WORD = 16'hA5C3
) (
  // Clock
  input  wire logic               clk,
  // Device pins
  input  wire wfe_pkg::ctl_pins_t control_pins,
  output var  logic [5:0]         handshake_inputs,
  output var  logic [15:0]        data_bus_in,
  // Bench controls
  input  wire logic [5:0]         hs_static,
  input  wire logic [3:0]         ready_delay
);
  import wfe_pkg::*;
  logic [3:0]  wait_cnt  = 4'h0;
  logic        ready     = 1'b0;
  logic [15:0] idle_word = 16'h5A5A;

  // Ready on line 0 answers a low strobe on control output 0
  always @(posedge clk) begin
    idle_word <= ~idle_word;
    if (control_pins.level[0] !== 1'b0) begin
      wait_cnt <= 4'h0;
      ready    <= 1'b0;
    end else if (wait_cnt >= ready_delay) begin
      ready <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  assign handshake_inputs = hs_static | {5'h00, ready};
  // Released bus toggles so a stale word cannot pass for a capture
  assign data_bus_in = (control_pins.level[1] === 1'b0 && control_pins.oe_n[1] === 1'b0) ? READ_WORD : idle_word;
endmodule : peripheral_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import wfe_pkg::*;
  localparam logic [15:0] RW = 16'hA5C3;
  logic        clk, reset, programmable_fifo_flag, tc_expired, e;
  logic        fifo_advance, fifo_store, waveform_state_interrupt, waveform_done;
  reg_req_t    req;
  logic [31:0] rdata, v, ctrl;
  logic [5:0]  handshake_inputs, hs_static;
  logic [15:0] out_fifo_word, data_bus_in, fifo_store_word, last_store;
  data_pins_t  data_bus_out;
  ctl_pins_t   control_pins, first_pins;
  logic [8:0]  waveform_address_bus, a0;
  logic [7:0]  len;
  logic [3:0]  ready_delay;
  int          errors, compares, exp_len;
  int          hist[64];
  int          cnt[4];

  waveform_state_instruction_decoder waveform_state_instruction_decoder_i (.clk(clk), .reset(reset),
    .req(req), .rdata(rdata), .handshake_inputs(handshake_inputs),
    .programmable_fifo_flag(programmable_fifo_flag), .tc_expired(tc_expired), .out_fifo_word(out_fifo_word),
    .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .fifo_advance(fifo_advance),
    .fifo_store(fifo_store), .fifo_store_word(fifo_store_word), .control_pins(control_pins),
    .waveform_address_bus(waveform_address_bus), .waveform_state_interrupt(waveform_state_interrupt),
    .waveform_done(waveform_done));
  peripheral_model #(.READ_WORD(RW)) peripheral_model_i (.clk(clk), .control_pins(control_pins),
    .handshake_inputs(handshake_inputs), .data_bus_in(data_bus_in), .hs_static(hs_static),
    .ready_delay(ready_delay));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask : rd

  task automatic prog(input int s, input logic [7:0] lb, op, lf, out);
    wr(8'(s * 4), {out, lf, op, lb});
  endtask : prog

  // Counts per run: 0 advance, 1 interrupt, 2 store, 3 data drive cycles
  task automatic run();
    int i;
    hist = '{default: 0};
    cnt = '{default: 0};
    a0 = waveform_address_bus;
    wr(REG_CONTROL, ctrl | 32'h1);
    for (i = 0; i < 1000; i++) begin
      #1;
      if (i == 0) first_pins = control_pins;
      hist[control_pins.level]++;
      cnt[0] += int'(fifo_advance === 1'b1);
      cnt[1] += int'(waveform_state_interrupt === 1'b1);
      cnt[2] += int'(fifo_store === 1'b1);
      cnt[3] += int'(data_bus_out.oe_n === 1'b0 && data_bus_out.value === out_fifo_word);
      if (fifo_store === 1'b1) last_store = fifo_store_word;
      if (waveform_done === 1'b1) break;
      @(posedge clk);
    end
    if (i == 1000) begin
      errors++;
      $display("CHECK FAILED waveform_done expected 1 seen 0");
      report_and_stop();
    end
  endtask : run

  initial begin
    reset = 1'b1;
    req = '0;
    hs_static = 6'h0;
    ready_delay = 4'h0;
    programmable_fifo_flag = 1'b0;
    tc_expired = 1'b0;
    out_fifo_word = 16'h3C5A;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("idle pins", {6'h3F, 6'h00}, control_pins);
    check("data oe_n", 1, data_bus_out.oe_n);
    rd(REG_STATUS, v);
    check("status", {25'h0, IDLE_STATE, 4'h0}, v);
    rd(8'h3C, v);
    check("unmapped", 0, v);
    rd(8'h18, v);
    check("instr reset", INSTR_RST, v);
    wr(8'h18, 32'h1234_5678);
    rd(8'h18, v);
    check("instr rw", 32'h1234_5678, v);
    // Fixed states: length, entry tasks, data drive in a write wave
    ctrl = 32'h3F0C;
    prog(1, 8'h3F, 8'h01, 8'h00, 8'h2A);
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 3; j++) begin
        len = (j == 0) ? 8'h01 : (j == 1) ? 8'h03 : 8'h00;
        exp_len = (len == 8'h00) ? 256 : int'(len);
        prog(0, len, k ? 8'hDE : 8'h00, 8'hFF, 8'h15);
        run();
        check("length", exp_len, hist[6'h15]);
        check("decision cycles", 1, hist[6'h2A]);
        check("interrupt", k, cnt[1]);
        check("advance", k, cnt[0]);
        check("drive", k * exp_len, cnt[3]);
        check("address", 9'(a0 + k), waveform_address_bus);
      end
    end
    // Wait on a slow or prompt ready, with and without repeat
    for (int r = 0; r < 2; r++) begin
      for (int d = 0; d < 8; d += 7) begin
        ready_delay <= 4'(d);
        prog(0, 8'(r * 128 + 8), 8'h09, 8'h00, 8'h3E);
        run();
        // Upper bound leaves room for the input synchroniser
        e = (hist[6'h3E] > d) && (hist[6'h3E] <= d + 8);
        check("wait", 1, e);
        check("loop address", r ? hist[6'h3E] : 1, 9'(waveform_address_bus - a0));
      end
    end
    prog(1, 8'h3F, 8'h01, 8'h00, 8'h11);
    prog(2, 8'h3F, 8'h01, 8'h00, 8'h22);
    for (int c = 0; c < 16; c++) begin
      wr(REG_READY_CFG, {24'h0, c[1], 7'h0});
      programmable_fifo_flag <= c[0];
      prog(0, 8'h0A, 8'h01, {c[3:2], 6'h3E}, 8'h31);
      e = (c[3:2] == 2'd1) ? (c[1] | c[0]) : (c[3:2] == 2'd2) ? (c[1] ^ c[0]) : (c[1] & c[0]);
      run();
      check("function", {e, !e}, {hist[6'h11] == 1, hist[6'h22] == 1});
    end
    for (int c = 0; c < 8; c++) begin
      wr(REG_READY_CFG, (c > 5) ? 32'h20 : 32'h0);
      hs_static <= (c == 6) ? 6'h20 : (c < 6) ? 6'(1 << c) : 6'h0;
      tc_expired <= (c == 7);
      prog(0, 8'h0A, 8'h01, {2'b00, c > 5 ? 3'd5 : 3'(c), c > 5 ? 3'd5 : 3'(c)}, 8'h31);
      run();
      check("term", c != 6, hist[6'h11]);
    end
    hs_static <= 6'h0;
    tc_expired <= 1'b0;
    ctrl = 32'h3F02;
    prog(0, 8'h02, 8'h00, 8'h00, 8'h5A);
    run();
    check("tri enables", 6'h3A, first_pins.oe_n);
    prog(0, 8'h02, 8'h00, 8'h00, 8'hF5);
    run();
    check("tri levels", {6'h30, 4'h5}, {first_pins.oe_n, first_pins.level[3:0]});
    ctrl = 32'h3F00;
    wr(REG_PIN_CFG, 32'h03);
    prog(0, 8'h02, 8'h00, 8'h00, 8'h01);
    run();
    check("open drain", {6'h00, 6'h01}, first_pins);
    wr(REG_PIN_CFG, 32'h0);
    // Read wave: FIFO store, single register, accumulator, no sample
    ctrl = 32'h3F04;
    prog(0, 8'h04, 8'h04, 8'h00, 8'h3D);
    prog(2, 8'h3F, 8'h01, 8'h00, 8'h2A);
    for (int m = 0; m < 4; m++) begin
      wr(REG_SINGLE_DATA, 32'h0);
      wr(REG_CRC_ACCUM, 32'h0);
      prog(1, 8'h02, (m == 0) ? 8'h02 : (m == 1) ? 8'h22 : (m == 2) ? 8'h26 : 8'h00, 8'h00, 8'h3D);
      run();
      check("store", m == 0, cnt[2]);
      check("read advance", 0, cnt[0]);
      if (m == 0) check("word", RW, last_store);
      rd(REG_SINGLE_DATA, v);
      check("single", (m == 1) ? RW : 16'h0, v);
      rd(REG_CRC_ACCUM, v);
      check("crc", (m == 2) ? RW : 16'h0, v);
    end
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
